//--- rtl/fault_status_pkg.sv
// Operation
// - Module fault word: bit15 group fault, bit10 calibrating, bit9 cal fault, others zero.
// - Group fault flag set whenever any channel fault word bit is set.
// - Calibrating flag while any channel calibrates; forces active-mode fault bits set.
// - Module cal fault bit9 set when any channel status bit7 set.
// - Fault bit n is channel n; 16, 8 or 4 channels by wiring.
// - Normally a channel fault bit follows its underrange or overrange bit.
// - During calibration fault word is ffff, 00ff or 000f by wiring mode.
// - Communication failure forces fault word ffff in every wiring mode.
// - Status byte: cal fault, under, over, rate, low, high, low-low, high-high.
// - Channel cal fault bit set when its calibration ends badly.
// - Underrange set when input at or below minimum detectable value.
// - Overrange set when input at or above maximum detectable value.
// - Rate alarm set above rate limit, cleared below it unless latched.
// - Low alarm set below low limit, held until input rises past trigger.
// - High alarm set above high limit, held until input falls past trigger.
// - Low-low alarm set below its limit, held until input rises past trigger.
// - High-high alarm set above its limit, held until input falls past trigger.
// - Latched alarm stays set after condition clears until explicitly unlatched.
// - With deadband, limit alarm stays set while input is inside the deadband.
// - Single-ended wiring gives no status bits 0..4; they read inactive.
`default_nettype none
package fault_status_pkg;

  typedef enum logic [1:0] {
    WIRE_SINGLE = 2'b00,
    WIRE_DIFF   = 2'b01,
    WIRE_HSDIFF = 2'b10
  } wiring_mode_t;

  localparam int NUM_CHANNELS = 16;
  localparam int VALUE_WIDTH  = 16;

  // Status byte fields
  localparam int ST_CAL_ERR   = 7;
  localparam int ST_BELOW     = 6;
  localparam int ST_ABOVE     = 5;
  localparam int ST_SLOPE     = 4;
  localparam int ST_LOW       = 3;
  localparam int ST_HIGH      = 2;
  localparam int ST_LOW_LOW   = 1;
  localparam int ST_HIGH_HIGH = 0;

  // Module fault word fields
  localparam int MF_GROUP     = 15;
  localparam int MF_CAL_BUSY  = 10;
  localparam int MF_CAL_ERR   = 9;

  // Channel fault word values while calibrating or with link lost
  localparam logic [15:0] CF_MASK_SINGLE = 16'hffff;
  localparam logic [15:0] CF_MASK_DIFF   = 16'h00ff;
  localparam logic [15:0] CF_MASK_HSDIFF = 16'h000f;
  localparam logic [15:0] CF_ALL_SET     = 16'hffff;

  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET     = 16'h0000;

endpackage : fault_status_pkg
`default_nettype wire

//--- rtl/limit_alarm.sv
`default_nettype none
// One limit alarm with deadband hysteresis and optional latch
module limit_alarm #(
  parameter int WIDTH = 16
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    update_in,
  input  wire logic                    enable_in,
  input  wire logic                    is_high_in,
  input  wire logic                    latch_in,
  input  wire logic                    unlatch_in,
  input  wire logic signed [WIDTH-1:0] value_in,
  input  wire logic signed [WIDTH-1:0] limit_in,
  input  wire logic        [WIDTH-1:0] deadband_in,
  output logic                         alarm_out
);
  logic signed [WIDTH:0] trigger;
  logic                  trip;
  logic                  release_ok;
  logic                  alarm_d;
  logic                  alarm_q;

  // Trigger point sits deadband away from the limit, inside the normal band
  always_comb begin
    if (is_high_in) begin
      trigger = $signed({limit_in[WIDTH-1], limit_in}) - $signed({1'b0, deadband_in});
    end else begin
      trigger = $signed({limit_in[WIDTH-1], limit_in}) + $signed({1'b0, deadband_in});
    end
    if (is_high_in) begin
      trip       = value_in > limit_in;
      release_ok = $signed({value_in[WIDTH-1], value_in}) < trigger;
    end else begin
      trip       = value_in < limit_in;
      release_ok = $signed({value_in[WIDTH-1], value_in}) > trigger;
    end
    alarm_d = alarm_q;
    if (!enable_in) begin
      alarm_d = 1'b0;
    end else if (trip) begin
      alarm_d = 1'b1;
    end else if (alarm_q && release_ok && (!latch_in || unlatch_in)) begin
      alarm_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      alarm_q <= 1'b0;
    end else if (update_in) begin
      alarm_q <= alarm_d;
    end
  end

  assign alarm_out = alarm_q;
endmodule : limit_alarm
`default_nettype wire

//--- rtl/channel_status.sv
`default_nettype none
// Status byte of one channel
module channel_status
  import fault_status_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    update_in,
  input  wire logic                    alarms_en_in,
  input  wire logic                    cal_bad_in,
  input  wire logic                    cal_clear_in,
  input  wire logic signed [WIDTH-1:0] value_in,
  input  wire logic signed [WIDTH-1:0] min_in,
  input  wire logic signed [WIDTH-1:0] max_in,
  input  wire logic        [WIDTH-1:0] slope_in,
  input  wire logic        [WIDTH-1:0] slope_limit_in,
  input  wire logic signed [WIDTH-1:0] low_in,
  input  wire logic signed [WIDTH-1:0] high_in,
  input  wire logic signed [WIDTH-1:0] low_low_in,
  input  wire logic signed [WIDTH-1:0] high_high_in,
  input  wire logic        [WIDTH-1:0] deadband_in,
  input  wire logic                    latch_in,
  input  wire logic                    unlatch_in,
  output logic                   [7:0] status_out
);
  logic       cal_err_q;
  logic       below_q;
  logic       above_q;
  logic       slope_q;
  logic [3:0] limit_al;

  // Calibration error sticks until a fresh calibration clears it; set wins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cal_err_q <= 1'b0;
    end else if (cal_bad_in) begin
      cal_err_q <= 1'b1;
    end else if (cal_clear_in) begin
      cal_err_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      below_q <= 1'b0;
      above_q <= 1'b0;
      slope_q <= 1'b0;
    end else if (update_in) begin
      below_q <= value_in <= min_in;
      above_q <= value_in >= max_in;
      if (!alarms_en_in) begin
        slope_q <= 1'b0;
      end else if (slope_in > slope_limit_in) begin
        slope_q <= 1'b1;
      end else if (slope_in < slope_limit_in && (!latch_in || unlatch_in)) begin
        slope_q <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_lim
    limit_alarm #(.WIDTH(WIDTH)) u_alarm (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .update_in  (update_in),
      .enable_in  (alarms_en_in),
      .is_high_in (i == ST_HIGH || i == ST_HIGH_HIGH),
      .latch_in   (latch_in),
      .unlatch_in (unlatch_in),
      .value_in   (value_in),
      .limit_in   (i == ST_LOW ? low_in : i == ST_HIGH ? high_in :
                   i == ST_LOW_LOW ? low_low_in : high_high_in),
      .deadband_in(deadband_in),
      .alarm_out  (limit_al[i])
    );
  end

  assign status_out = {cal_err_q, below_q, above_q, slope_q, limit_al};
endmodule : channel_status
`default_nettype wire

//--- rtl/analog_input_fault_status.sv
`default_nettype none
module analog_input_fault_status
  import fault_status_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int WIDTH  = 16
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           rst_in,
  input  wire fault_status_pkg::wiring_mode_t wiring_mode_in,
  input  wire logic                           update_in,
  input  wire logic                           link_fail_in,
  input  wire logic [NUM_CH-1:0]              cal_active_in,
  input  wire logic [NUM_CH-1:0]              cal_bad_in,
  input  wire logic [NUM_CH-1:0]              unlatch_in,
  input  wire logic [NUM_CH-1:0]              latch_en_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        value_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        slope_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        min_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        max_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        slope_limit_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        low_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        high_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        low_low_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        high_high_in,
  input  wire logic [NUM_CH*WIDTH-1:0]        deadband_in,
  output logic [NUM_CH*8-1:0]                 per_channel_status_out,
  output logic [15:0]                         channel_fault_summary_out,
  output logic [15:0]                         module_fault_summary_out
);
  import fault_status_pkg::*;

  if (NUM_CH != NUM_CHANNELS) begin : g_bad_ch
    $error("NUM_CH must be 16");
  end
  if (WIDTH < 2) begin : g_bad_w
    $error("WIDTH too small");
  end

  // ---------------------------------------------------------------
  // Alarm enable, calibration busy and update strobe
  // ---------------------------------------------------------------
  // Frame context is taken with the update pulse, so all three words agree
  logic [NUM_CH*8-1:0] status;
  logic                update_q;
  logic [15:0]         mode_mask;
  logic                alarms_en;
  logic                cal_busy;
  logic [15:0]         cf_d;
  logic [15:0]         mf_d;
  logic [15:0]         cf_q;
  logic [15:0]         mf_q;
  logic [NUM_CH*8-1:0] status_q;
  logic [15:0]         mask_q;
  logic                link_q;
  logic                cal_q;

  // Mode 11 is served as single-ended, alarms off as well
  assign alarms_en = wiring_mode_in inside {WIRE_DIFF, WIRE_HSDIFF};
  assign cal_busy  = |cal_active_in;

  // Summaries follow one cycle after the channel bytes settle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      update_q <= 1'b0;
    end else begin
      update_q <= update_in;
    end
  end

  // ---------------------------------------------------------------
  // Per channel status
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    channel_status #(.WIDTH(WIDTH)) u_status (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (rst_in),
      .update_in     (update_in),
      .alarms_en_in  (alarms_en),
      .cal_bad_in    (cal_bad_in[c]),
      .cal_clear_in  (cal_active_in[c]),
      .value_in      (value_in[c*WIDTH +: WIDTH]),
      .min_in        (min_in[c*WIDTH +: WIDTH]),
      .max_in        (max_in[c*WIDTH +: WIDTH]),
      .slope_in      (slope_in[c*WIDTH +: WIDTH]),
      .slope_limit_in(slope_limit_in[c*WIDTH +: WIDTH]),
      .low_in        (low_in[c*WIDTH +: WIDTH]),
      .high_in       (high_in[c*WIDTH +: WIDTH]),
      .low_low_in    (low_low_in[c*WIDTH +: WIDTH]),
      .high_high_in  (high_high_in[c*WIDTH +: WIDTH]),
      .deadband_in   (deadband_in[c*WIDTH +: WIDTH]),
      .latch_in      (latch_en_in[c]),
      .unlatch_in    (unlatch_in[c]),
      .status_out    (status[c*8 +: 8])
    );
  end

  // ---------------------------------------------------------------
  // Summary words
  // ---------------------------------------------------------------
  always_comb begin
    case (wiring_mode_in)
      WIRE_DIFF:   mode_mask = CF_MASK_DIFF;
      WIRE_HSDIFF: mode_mask = CF_MASK_HSDIFF;
      default:     mode_mask = CF_MASK_SINGLE;
    endcase
  end

  // Mode, link and calibration state belong to the frame of the pulse
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_q <= CF_MASK_SINGLE;
      link_q <= 1'b0;
      cal_q  <= 1'b0;
    end else if (update_in) begin
      mask_q <= mode_mask;
      link_q <= link_fail_in;
      cal_q  <= cal_busy;
    end
  end

  always_comb begin
    cf_d = WORD_RESET;
    for (int c = 0; c < NUM_CH; c++) begin
      cf_d[c] = status[c*8 + ST_BELOW] | status[c*8 + ST_ABOVE];
    end
    cf_d = cf_d & mask_q;
    if (link_q) begin
      cf_d = CF_ALL_SET;
    end else if (cal_q) begin
      cf_d = mask_q;
    end
    mf_d = WORD_RESET;
    mf_d[MF_GROUP]    = |cf_d;
    mf_d[MF_CAL_BUSY] = cal_q;
    for (int c = 0; c < NUM_CH; c++) begin
      mf_d[MF_CAL_ERR] = mf_d[MF_CAL_ERR] | status[c*8 + ST_CAL_ERR];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cf_q     <= WORD_RESET;
      mf_q     <= WORD_RESET;
      status_q <= '0;
    end else if (update_q) begin
      cf_q     <= cf_d;
      mf_q     <= mf_d;
      status_q <= status;
    end
  end

  assign per_channel_status_out    = status_q;
  assign channel_fault_summary_out = cf_q;
  assign module_fault_summary_out  = mf_q;
endmodule : analog_input_fault_status
`default_nettype wire

//--- tb/fault_status_assertions.sv
`default_nettype none
module fault_status_checker
  import fault_status_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic                           sys_clk_in,
  input wire logic                           rst_in,
  input wire fault_status_pkg::wiring_mode_t wiring_mode_in,
  input wire logic                           update_in,
  input wire logic                           link_fail_in,
  input wire logic [NUM_CH-1:0]              cal_active_in,
  input wire logic [NUM_CH*8-1:0]            per_channel_status_out,
  input wire logic [15:0]                    channel_fault_summary_out,
  input wire logic [15:0]                    module_fault_summary_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        cal_any;
  logic        alarm_any;
  logic [15:0] rng;

  function automatic logic [15:0] mask_of(input wiring_mode_t m);
    return (m == WIRE_DIFF) ? 16'h00ff : (m == WIRE_HSDIFF) ? 16'h000f : 16'hffff;
  endfunction : mask_of

  always_comb begin
    cal_any   = 1'b0;
    alarm_any = 1'b0;
    rng       = 16'h0000;
    for (int c = 0; c < NUM_CH; c++) begin
      cal_any   = cal_any | per_channel_status_out[c*8+7];
      alarm_any = alarm_any | (|per_channel_status_out[c*8+:5]);
      rng[c]    = per_channel_status_out[c*8+6] | per_channel_status_out[c*8+5];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_mf_unused_bits: assert property (
    module_fault_summary_out[14:11] == 4'h0 && module_fault_summary_out[8:0] == 9'h000)
    else $error("unused module fault bits set");
  chk_group_follows: assert property (
    module_fault_summary_out[15] == (|channel_fault_summary_out))
    else $error("group fault disagrees with fault word");
  chk_cal_busy: assert property (
    update_in |-> ##2 module_fault_summary_out[10] == (|$past(cal_active_in, 2)))
    else $error("calibrating flag wrong");
  chk_cal_err_sum: assert property (
    module_fault_summary_out[9] == cal_any)
    else $error("module cal fault disagrees with status bytes");
  chk_range_fault: assert property (
    update_in && !link_fail_in && !(|cal_active_in)
    |-> ##2 channel_fault_summary_out == (rng & mask_of($past(wiring_mode_in, 2))))
    else $error("fault word disagrees with range bits");
  chk_cal_mask: assert property (
    update_in && !link_fail_in && (|cal_active_in)
    |-> ##2 channel_fault_summary_out == mask_of($past(wiring_mode_in, 2)))
    else $error("calibration fault word wrong");
  chk_link_all_set: assert property (
    update_in && link_fail_in |-> ##2 channel_fault_summary_out == 16'hffff)
    else $error("link fail fault word wrong");
  chk_single_no_alarm: assert property (
    update_in && wiring_mode_in != WIRE_DIFF && wiring_mode_in != WIRE_HSDIFF |-> ##2 !alarm_any)
    else $error("alarm bits in single-ended mode");
  chk_words_hold: assert property (
    !update_in |-> ##2 $stable(per_channel_status_out) && $stable(channel_fault_summary_out)
    && $stable(module_fault_summary_out))
    else $error("outputs moved without update");
endmodule : fault_status_checker

bind analog_input_fault_status fault_status_checker #(.NUM_CH(NUM_CH)) u_chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .wiring_mode_in(wiring_mode_in),
  .update_in(update_in),
  .link_fail_in(link_fail_in),
  .cal_active_in(cal_active_in),
  .per_channel_status_out(per_channel_status_out),
  .channel_fault_summary_out(channel_fault_summary_out),
  .module_fault_summary_out(module_fault_summary_out)
);
`default_nettype wire

//--- tb/owner_ctrl_model.sv
`default_nettype none
module owner_ctrl_model (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        drop_link_in,
  input  wire logic        update_in,
  input  wire logic [15:0] channel_fault_in,
  output logic             link_fail_out,
  output logic [15:0]      last_fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] seen_q;

  // Words land one cycle after the pulse edge, so take them one edge later
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      link_fail_out  <= 1'b0;
      seen_q         <= 2'b00;
      last_fault_out <= 16'h0000;
    end else begin
      link_fail_out <= drop_link_in;
      seen_q        <= {seen_q[0], update_in};
      if (seen_q[1]) begin
        last_fault_out <= channel_fault_in;
      end
    end
  end
endmodule : owner_ctrl_model
`default_nettype wire

//--- tb/analog_input_fault_status_test.sv
`default_nettype none
module analog_input_fault_status_test import fault_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         sys_clk_in, rst_in, update, link_fail, drop_link;
  wiring_mode_t mode;
  logic [15:0]  cal_active, cal_bad, unlatch, latch_en, cf, mf, seen_cf;
  logic [255:0] value, slope;
  logic [127:0] status;
  int           mismatches, n_tests;

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  analog_input_fault_status uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wiring_mode_in(mode), .update_in(update),
    .link_fail_in(link_fail), .cal_active_in(cal_active), .cal_bad_in(cal_bad),
    .unlatch_in(unlatch), .latch_en_in(latch_en), .value_in(value), .slope_in(slope),
    .min_in({16{16'hfc18}}), .max_in({16{16'h03e8}}), .slope_limit_in({16{16'h0064}}),
    .low_in({16{16'hfe0c}}), .high_in({16{16'h01f4}}), .low_low_in({16{16'hfce0}}),
    .high_high_in({16{16'h0320}}), .deadband_in({16{16'h0032}}),
    .per_channel_status_out(status), .channel_fault_summary_out(cf),
    .module_fault_summary_out(mf));

  owner_ctrl_model u_owner (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .drop_link_in(drop_link),
    .update_in(update), .channel_fault_in(cf), .link_fail_out(link_fail),
    .last_fault_out(seen_cf));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] st(input int c);
    return {8'h00, status[c*8+:8]};
  endfunction : st

  // Fixed two-cycle answer, so no polling is needed
  task automatic frame();
    update = 1'b1;
    @(negedge sys_clk_in);
    update = 1'b0;
    @(negedge sys_clk_in);
  endtask : frame

  task automatic t_range();
    value[0+:16]  = 16'hfc18;
    value[48+:16] = 16'h03e8;
    value[144+:16] = 16'h03e8;
    frame();
    check(cf, 16'h0009);
    check(mf, 16'h8000);
    check(st(0), 16'h004a);
    check(st(3), 16'h0025);
    check(st(0) & 16'h0002, 16'h0002);
    check(st(3) & 16'h0001, 16'h0001);
  endtask : t_range

  task automatic t_deadband();
    value = '0;
    value[48+:16] = 16'h01e0;
    frame();
    check(st(3), 16'h0004);
    check(st(0), 16'h0000);
    check(mf, 16'h0000);
    value[48+:16] = 16'h01b8;
    frame();
    check(st(3), 16'h0000);
  endtask : t_deadband

  task automatic t_latch();
    latch_en = 16'h0002;
    value[16+:16] = 16'h0258;
    frame();
    check(st(1), 16'h0004);
    value[16+:16] = 16'h0000;
    frame();
    check(st(1), 16'h0004);
    unlatch = 16'h0002;
    frame();
    unlatch = 16'h0000;
    latch_en = 16'h0000;
    check(st(1), 16'h0000);
  endtask : t_latch

  task automatic t_slope();
    logic [15:0] rates [3] = '{16'h0096, 16'h0064, 16'h0032};
    logic [15:0] exps [3] = '{16'h0010, 16'h0010, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      slope[32+:16] = rates[i];
      frame();
      check(st(2), exps[i]);
    end
  endtask : t_slope

  task automatic t_single();
    mode = WIRE_SINGLE;
    slope[32+:16] = 16'h0096;
    value[80+:16] = 16'h03e8;
    frame();
    check(st(2), 16'h0000);
    check(st(5), 16'h0020);
    check(cf, 16'h0020);
    slope = '0;
    value = '0;
  endtask : t_single

  task automatic t_cal();
    logic [15:0] masks [3] = '{16'hffff, 16'h00ff, 16'h000f};
    cal_active = 16'h0010;
    for (int i = 0; i < 3; i++) begin
      mode = wiring_mode_t'(i);
      frame();
      check(cf, masks[i]);
      check(mf, 16'h8400);
    end
    cal_bad = 16'h0010;
    cal_active = 16'h0000;
    @(negedge sys_clk_in);
    cal_bad = 16'h0000;
    frame();
    check(st(4), 16'h0080);
    check(mf, 16'h0200);
    cal_active = 16'h0010;
    @(negedge sys_clk_in);
    cal_active = 16'h0000;
    frame();
    check(mf, 16'h0000);
  endtask : t_cal

  task automatic t_link();
    drop_link = 1'b1;
    @(negedge sys_clk_in);
    frame();
    check(cf, 16'hffff);
    check(mf, 16'h8000);
    @(negedge sys_clk_in);
    check(seen_cf, 16'hffff);
    drop_link = 1'b0;
    @(negedge sys_clk_in);
    frame();
    check(cf, 16'h0000);
  endtask : t_link

  task automatic t_back_to_back();
    update = 1'b1;
    value[0+:16] = 16'hfc18;
    @(negedge sys_clk_in);
    value[0+:16] = 16'h0000;
    @(negedge sys_clk_in);
    update = 1'b0;
    check(cf, 16'h0001);
    @(negedge sys_clk_in);
    check(cf, 16'h0000);
  endtask : t_back_to_back

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_in = 1'b1;
    update = 1'b0;
    drop_link = 1'b0;
    mode = WIRE_DIFF;
    {cal_active, cal_bad, unlatch, latch_en} = '0;
    value = '0;
    slope = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    check(mf, 16'h0000);
    check(st(0), 16'h0000);
    check(cf, 16'h0000);
    t_range();
    t_deadband();
    t_latch();
    t_slope();
    t_single();
    t_cal();
    t_link();
    t_back_to_back();
    report_and_stop();
  end
endmodule : analog_input_fault_status_test
`default_nettype wire
